// *** hw/xcv_ctrl.sv ***
// Transceiver direction/enable outputs and the dual select/address pin.
// Assumes access requests and configuration arrive on clk from core logic;
// only the bus grant acknowledge is generated here from a sampled request.
// Functional notes
// - Dual pin is select or latched address two
// - Select range comes from software configuration
// - Dual pin stays driven during bus grant
// - Latched address holds during bus grant
// - Direction low during reads
// - Direction high during writes
// - Enable low for memory and I/O accesses that keep the direction
// - Enable high whenever direction changes
// - Reset drives enable high one clock, then floats
// - Grant acknowledge floats bus control outputs
// - Select active low inside programmed region
`timescale 1ns/1ps
`include "xcv_defines.svh"
module xcv_ctrl #(
    parameter int ADDR_W = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire xcv_pkg::xcv_acc_s acc,
    input wire logic bus_hold_req,
    input wire logic addr_mode_sel,
    input wire logic [ADDR_W-1:0] sel_base,
    input wire logic [ADDR_W-1:0] sel_limit,
    input wire logic sel_in_io,
    output logic bus_grant_ack,
    output xcv_pkg::xcv_pin_s transfer_direction,
    output xcv_pkg::xcv_pin_s transceiver_enable_n,
    output xcv_pkg::xcv_pin_s periph_select_seven_or_latched_addr
);
    // Hold request is a pin: two flops before use
    logic hold_meta_q, hold_meta_d; // First stage, read only by second
    logic hold_sync_q, hold_sync_d; // Usable hold level
    logic grant_q, grant_d; // Bus granted to other master
    logic dir_q, dir_d; // Current direction level
    logic den_q, den_d; // Enable level, active low
    logic dual_q, dual_d; // Dual pin level
    logic addr2_q, addr2_d; // Latched address bit two
    xcv_pkg::xcv_rst_e rst_q, rst_d; // Reset sequencing
    logic [7:0] rcnt_q, rcnt_d; // Cycles of driven-high enable
    logic in_range; // Access hits the programmed region
    // Region compare against software-set bounds
    always_comb begin
        in_range = acc.active && (acc.is_io == sel_in_io) &&
            (acc.addr[ADDR_W-1:0] >= sel_base) &&
            (acc.addr[ADDR_W-1:0] <= sel_limit);
    end
    // Next-state logic for the whole block
    always_comb begin
        hold_meta_d = bus_hold_req;
        hold_sync_d = hold_meta_q;
        grant_d = hold_sync_q && !acc.active; // Grant only between cycles
        dir_d = dir_q;
        den_d = `XCV_PIN_IDLE;
        addr2_d = addr2_q;
        dual_d = dual_q;
        rst_d = xcv_pkg::XCV_RUN;
        rcnt_d = rcnt_q;
        if (!grant_q && acc.active) begin
            // Direction follows the access; enable waits if it flips
            dir_d = acc.is_write;
            den_d = (dir_q != acc.is_write);
            addr2_d = acc.addr[2];
        end
        if (addr_mode_sel) begin
            // Latched copy; frozen in grant since no access runs
            dual_d = addr2_d;
        end else begin
            dual_d = !(in_range && !grant_q);
        end
        if (grant_q) begin
            dual_d = addr_mode_sel ? addr2_q : `XCV_PIN_IDLE;
        end
    end
    // Register stage; reset sequence drives enable for one clock
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_meta_q <= 1'b0;
            hold_sync_q <= 1'b0;
            grant_q <= 1'b0;
            dir_q <= 1'b0;
            den_q <= `XCV_PIN_IDLE;
            addr2_q <= 1'b0;
            dual_q <= `XCV_PIN_IDLE;
            // Count driven cycles, then float; any other code, the
            // unknown one at power-up included, starts a fresh drive
            if (rst_q == xcv_pkg::XCV_RST_DRIVE) begin
                if (rcnt_q >= 8'(`XCV_RESET_DRIVE_CYC)) begin
                    rst_q <= xcv_pkg::XCV_RST_FLOAT;
                    rcnt_q <= rcnt_q;
                end else begin
                    rst_q <= xcv_pkg::XCV_RST_DRIVE;
                    rcnt_q <= rcnt_q + 8'h01;
                end
            end else if (rst_q == xcv_pkg::XCV_RST_FLOAT) begin
                // Stay floating until reset is released
                rst_q <= xcv_pkg::XCV_RST_FLOAT;
                rcnt_q <= rcnt_q;
            end else begin
                rst_q <= xcv_pkg::XCV_RST_DRIVE;
                rcnt_q <= 8'h01;
            end
        end else if (ce) begin
            hold_meta_q <= hold_meta_d;
            hold_sync_q <= hold_sync_d;
            grant_q <= grant_d;
            dir_q <= dir_d;
            den_q <= den_d;
            addr2_q <= addr2_d;
            dual_q <= dual_d;
            rst_q <= rst_d;
            rcnt_q <= rcnt_d;
        end
    end
    // Pin drivers; grant floats direction and enable at once
    always_comb begin
        bus_grant_ack = grant_q;
        transfer_direction.o = dir_q;
        transfer_direction.oe = !grant_q && !rst &&
            (rst_q == xcv_pkg::XCV_RUN);
        transceiver_enable_n.o = den_q;
        transceiver_enable_n.oe = !grant_q &&
            (rst_q != xcv_pkg::XCV_RST_FLOAT) &&
            !(rst && rst_q == xcv_pkg::XCV_RST_FLOAT);
        periph_select_seven_or_latched_addr.o = dual_q;
        periph_select_seven_or_latched_addr.oe = 1'b1;
    end
endmodule

// *** hw/xcv_defines.svh ***
// Timing constants and pin-level fields for the transceiver control block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef XCV_DEFINES_SVH
`define XCV_DEFINES_SVH
// Clock period of the processor clock in ns
`define XCV_CLK_PERIOD_NS 40
// Enable held high for one clock when reset starts
`define XCV_RESET_DRIVE_NS 40
// Cycles of driven-high enable at reset entry, rounded down, at least one
`define XCV_RESET_DRIVE_CYC \
    ((`XCV_RESET_DRIVE_NS / `XCV_CLK_PERIOD_NS) < 1 ? 1 : \
    (`XCV_RESET_DRIVE_NS / `XCV_CLK_PERIOD_NS))
// Reset value of the dual pin and of the transceiver enable
`define XCV_PIN_IDLE 1'b1
// Reset value of the pin mode select (peripheral select)
`define XCV_MODE_RESET 1'b0
`endif

// *** hw/xcv_pkg.sv ***
// Types for the transceiver control block.
// Assumes the defines header is compiled alongside.
package xcv_pkg;
    // Pin with drive enable, high while driven
    typedef struct packed {
        logic o;
        logic oe;
    } xcv_pin_s;
    // Bus access request from the bus unit, same clock
    typedef struct packed {
        logic active;
        logic is_write;
        logic is_io;
        logic [19:0] addr;
    } xcv_acc_s;
    // Reset sequencing states
    typedef enum logic [2:0] {
        XCV_RUN = 3'b001,
        XCV_RST_DRIVE = 3'b010,
        XCV_RST_FLOAT = 3'b100
    } xcv_rst_e;
endpackage

// *** verif/xcv_master.sv ***
// Model of another bus master that asks for the local bus.
// Assumes clk is the processor clock and go comes from the bench.
`timescale 1ns/1ps
module xcv_master (
    input wire logic clk,
    input wire logic go,
    input wire logic grant,
    output logic req
);
int n = 0; // Cycles granted so far
initial req = 1'b0;
// Changes on the falling edge, frees the bus after six granted cycles
always @(negedge clk) begin
    n <= grant ? n + 1 : 0;
    if (go) req <= 1'b1;
    else if (n == 5) req <= 1'b0;
end
endmodule

// *** verif/xcv_ctrl_chk.sv ***
// Port assertions for xcv_ctrl, bound in at the foot.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module xcv_ctrl_chk #(parameter int ADDR_W = 20) (
    input wire logic clk, input wire logic rst, input wire logic ce,
    input wire xcv_pkg::xcv_acc_s acc, input wire logic addr_mode_sel,
    input wire logic [ADDR_W-1:0] sel_base, sel_limit,
    input wire logic sel_in_io, input wire logic bus_grant_ack,
    input wire xcv_pkg::xcv_pin_s transfer_direction, transceiver_enable_n,
    input wire xcv_pkg::xcv_pin_s periph_select_seven_or_latched_addr);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire xcv_pkg::xcv_pin_s dr = transfer_direction, en = transceiver_enable_n;
wire xcv_pkg::xcv_pin_s dp = periph_select_seven_or_latched_addr;
wire tk = ce && acc.active && !bus_grant_ack; // Access taken here
wire hit = acc.is_io == sel_in_io && acc.addr >= sel_base
    && acc.addr <= sel_limit;
sequence s_same; tk ##1 (tk && $stable(acc.is_write)); endsequence
sequence s_rst; $rose(rst) ##1 rst; endsequence
dir_map_a: assert property (tk |=> dr.o == $past(acc.is_write) && dr.oe)
    else $error("direction wrong");
en_active_a: assert property (s_same |=> !en.o && en.oe)
    else $error("enable not low");
en_flip_a: assert property ($changed(dr.o) && dr.oe && $past(dr.oe) |-> en.o)
    else $error("enable low on flip");
rst_en_a: assert property (disable iff (1'b0) s_rst |->
    (en.o && en.oe && !dr.oe) ##1 !en.oe) else $error("reset drive");
grant_float_a: assert property (bus_grant_ack |-> !dr.oe && !en.oe)
    else $error("driven in grant");
dual_drive_a: assert property (dp.oe)
    else $error("dual pin floats");
addr_hold_a: assert property (bus_grant_ack && $past(bus_grant_ack) &&
    addr_mode_sel && $past(addr_mode_sel) |-> $stable(dp.o))
    else $error("address moved");
sel_map_a: assert property (tk && !addr_mode_sel |=> dp.o == !$past(hit))
    else $error("select wrong");
endmodule
bind xcv_ctrl xcv_ctrl_chk #(.ADDR_W(ADDR_W)) xcv_ctrl_chk_inst (.clk, .rst,
    .ce, .acc, .addr_mode_sel, .sel_base, .sel_limit, .sel_in_io,
    .bus_grant_ack, .transfer_direction, .transceiver_enable_n,
    .periph_select_seven_or_latched_addr);

// *** verif/xcv_ctrl_tb_top.sv ***
// Random bench for xcv_ctrl beside a second bus master.
// Assumes the checker binds itself into the design.
`timescale 1ns/1ps
module xcv_ctrl_tb_top;
localparam logic [19:0] LO = 20'h0_0100, HI = 20'h0_01FF;
logic clk = 0, rst = 1, ce = 1, md = 0, io = 0, go = 0, req, gnt;
logic tk = 0, pt = 0, pg = 0, pw = 0, ld = 0;
xcv_pkg::xcv_acc_s acc = '0, p = '0;
xcv_pkg::xcv_pin_s dr, en, dp;
logic [19:0] ed [4] = '{20'h0_00FF, LO, HI, 20'h0_0200}; // Edges
int seed = 52990, err_total = 0, num_checks = 0, r;
initial forever #20 clk = ~clk;
xcv_ctrl xcv_ctrl_inst (.clk, .rst, .ce, .acc, .bus_hold_req(req),
    .addr_mode_sel(md), .sel_base(LO), .sel_limit(HI), .sel_in_io(io),
    .bus_grant_ack(gnt), .transfer_direction(dr),
    .transceiver_enable_n(en), .periph_select_seven_or_latched_addr(dp));
xcv_master xcv_master_inst (.clk, .go, .grant(gnt), .req);
task chk(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
        err_total++;
        $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
endtask
// Select level expected for an access
function logic sel_n(xcv_pkg::xcv_acc_s a);
    return !(a.is_io == io && a.addr >= LO && a.addr <= HI);
endfunction
task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask
task do_rst;
    rst = 1;
    acc = '0;
    tk = 0;
    pg = 0;
    @(negedge clk);
    chk({en.o, en.oe, dr.oe}, 3'b110);
    repeat (4) @(negedge clk);
    chk({en.oe, dp.o, dp.oe}, 3'b011);
    rst = 0;
    repeat (2) @(negedge clk);
    $display("reset test done");
endtask
initial begin
    do_rst;
    repeat (600) begin
        @(negedge clk);
        if (gnt) chk({dr.oe, en.oe, dp.oe}, 3'b001);
        if (gnt && pg && md) chk(dp.o, ld);
        if (tk) begin
            chk({dr.o, dr.oe}, {p.is_write, 1'b1});
            chk(dp.o, md ? p.addr[2] : sel_n(p));
            if (pt) chk(en.o, p.is_write != pw);
            pw = p.is_write;
        end
        // New stimulus; mode only moves while nobody wants the bus
        pt = tk;
        pg = gnt;
        ld = dp.o;
        r = $random(seed);
        ce = r[2:0] != 0;
        go = r[9:4] == 0;
        if (r[15:10] == 0 && !req && !gnt) {md, io} = {!md, r[21]};
        acc.active = r[3] && !(req && !gnt);
        {acc.is_write, acc.is_io} = r[17:16];
        acc.addr = r[18] ? ed[r[20:19]] : r[31:12];
        tk = ce && acc.active && !gnt;
        p = acc;
    end
    $display("random test done");
    do_rst;
    final_report;
end
// About 620 cycles are needed; ten times that cuts a hang
initial begin
    #250000;
    err_total++;
    final_report;
end
endmodule
